// *** hw/pbio_pkg.sv ***
// Package for the general-purpose pin port with input remapping.
// Assumes one 50 MHz system clock and an AXI4-Lite master with 16 address bits used.
package pbio_pkg;
    localparam int          ADDR_W = 16;
    localparam int          PINS   = 16;
    localparam int          SEL_W  = 4;

    localparam logic [15:0] OFS_ANALOG   = 16'h6100;
    localparam logic [15:0] OFS_DIR      = 16'h6110;
    localparam logic [15:0] OFS_LEVEL    = 16'h6120;
    localparam logic [15:0] OFS_LATCH    = 16'h6130;
    localparam logic [15:0] OFS_ODC      = 16'h6140;
    localparam logic [15:0] OFS_PU       = 16'h6150;
    localparam logic [15:0] OFS_PD       = 16'h6160;
    localparam logic [15:0] OFS_CNCON    = 16'h6170;
    localparam logic [15:0] OFS_CNEN     = 16'h6180;
    localparam logic [15:0] OFS_CNSTAT   = 16'h6190;
    localparam logic [15:0] OFS_IRQSTAT  = 16'h61a0;
    localparam logic [15:0] OFS_IRQMASK  = 16'h61b0;
    localparam logic [15:0] OFS_INSEL0   = 16'h6200;
    localparam logic [15:0] INSEL_STRIDE = 16'h0010;

    localparam logic [1:0]  OP_WRITE = 2'h0;
    localparam logic [1:0]  OP_CLR   = 2'h1;
    localparam logic [1:0]  OP_SET   = 2'h2;
    localparam logic [1:0]  OP_INV   = 2'h3;

    localparam logic [15:0] PIN_MASK_FULL    = 16'hffff;
    localparam logic [15:0] PIN_MASK_REDUCED = 16'hefbf;
    localparam logic [15:0] ANALOG_MASK      = 16'hf00f;
    localparam logic [15:0] CNCON_MASK       = 16'ha000;
    localparam int          CN_ON_BIT        = 15;
    localparam int          CN_IDLE_BIT      = 13;
    localparam logic [15:0] RST_DIR          = 16'hffff;
    localparam logic [15:0] RST_ZERO         = 16'h0000;
    localparam logic [15:0] RST_LATCH        = 16'h0000;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } pbio_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pbio_axi_rsp_t;
endpackage

// *** hw/pbio_port_b_remap.sv ***
// Sixteen-pin port with its control registers, input remapping and change-notice interrupt.
// Assumes pins are external and asynchronous; peripheral outputs come from the same clock.
//
// Local design decision: the AXI4-Lite slave port.
module pbio_port_b_remap import pbio_pkg::*; #(
    parameter int NUM_INPUTS = 4,
    parameter bit REDUCED    = 1'b0
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire pbio_axi_req_t         axiReq,
    output pbio_axi_rsp_t              axiRsp,
    input  wire logic [PINS-1:0]       pinIn,
    output logic [PINS-1:0]            pinOut,
    output logic [PINS-1:0]            pinOutEnN,
    output logic [PINS-1:0]            pullUpEn,
    output logic [PINS-1:0]            pullDownEn,
    output logic [PINS-1:0]            analogEn,
    input  wire logic [PINS-1:0]       periphOutEn,
    input  wire logic [PINS-1:0]       periphOutVal,
    input  wire logic                  idleMode,
    output logic [NUM_INPUTS-1:0]      remapIn,
    output logic                       irq
);
    typedef struct packed {
        logic [NUM_INPUTS-1:0][SEL_W-1:0] insel;
        logic [15:0]                      analog;
        logic [15:0]                      dir;
        logic [15:0]                      latch;
        logic [15:0]                      odc;
        logic [15:0]                      pu;
        logic [15:0]                      pd;
        logic [15:0]                      cncon;
        logic [15:0]                      cnen;
        logic [15:0]                      cnstat;
        logic [15:0]                      irqStat;
        logic [15:0]                      irqMask;
        logic [15:0]                      s1;
        logic [15:0]                      s2;
        logic [15:0]                      s3;
        logic [15:0]                      level;
        logic [NUM_INPUTS-1:0]            remap;
        logic                             awHave;
        logic [ADDR_W-1:0]                awAddr;
        logic                             wHave;
        logic [31:0]                      wData;
        logic [3:0]                       wStrb;
        logic                             bValid;
        logic [1:0]                       bResp;
        logic                             rValid;
        logic [31:0]                      rData;
        logic [1:0]                       rResp;
        logic [15:0]                      pinOut;
        logic [15:0]                      pinOeN;
    } pbio_state_t;

    localparam logic [15:0] IMPL_MASK  = REDUCED ? PIN_MASK_REDUCED : PIN_MASK_FULL;
    localparam logic [15:0] DIR_RESET  = RST_DIR & IMPL_MASK;
    localparam logic [15:0] ANLG_RESET = ANALOG_MASK & IMPL_MASK;

    pbio_state_t st_r;
    pbio_state_t st_nxt;

    // Alias operations act only on the byte lanes that the strobes enable.
    function automatic logic [15:0] applyOp(input logic [15:0] old, input logic [15:0] d,
                                            input logic [15:0] m, input logic [1:0] op);
        logic [15:0] r;
        r = old;
        case (op)
            OP_WRITE: r = (old & ~m) | (d & m);
            OP_CLR:   r = old & ~(d & m);
            OP_SET:   r = old | (d & m);
            OP_INV:   r = old ^ (d & m);
            default:  r = old;
        endcase
        return r;
    endfunction

    logic              wrFire;
    logic              rdFire;
    logic [15:0]       wrBase;
    logic [1:0]        wrOp;
    logic [15:0]       wrData;
    logic [15:0]       wrMask;
    logic [15:0]       rdBase;
    logic [1:0]        rdOp;
    logic [15:0]       levelNew;
    logic [15:0]       cnEvent;
    logic [15:0]       periphWin;
    logic [15:0]       drvVal;
    logic              wrHit;
    logic              rdHit;
    logic [15:0]       rdVal;
    logic              clrCn;
    logic              clrIrq;
    logic [15:0]       selNew;

    always_comb begin
        st_nxt   = st_r;
        wrFire   = st_r.awHave && st_r.wHave && !st_r.bValid;
        rdFire   = axiReq.arvalid && !st_r.rValid;
        wrBase   = {st_r.awAddr[15:4], 4'h0};
        wrOp     = st_r.awAddr[3:2];
        wrData   = st_r.wData[15:0];
        wrMask   = {{8{st_r.wStrb[1]}}, {8{st_r.wStrb[0]}}} & IMPL_MASK;
        rdBase   = {axiReq.araddr[15:4], 4'h0};
        rdOp     = axiReq.araddr[3:2];
        wrHit    = 1'b0;
        rdHit    = 1'b0;
        rdVal    = 16'h0000;
        clrCn    = 1'b0;
        clrIrq   = 1'b0;
        selNew   = 16'h0000;

        // The first stage only feeds the second, so the filter sees settled values only.
        st_nxt.s1 = pinIn;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        levelNew  = st_r.level;
        for (int i = 0; i < PINS; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                levelNew[i] = st_r.s3[i];
            end
        end
        st_nxt.level = levelNew & IMPL_MASK;
        cnEvent = (levelNew ^ st_r.level) & st_r.cnen & IMPL_MASK;
        if (!st_r.cncon[CN_ON_BIT] || (st_r.cncon[CN_IDLE_BIT] && idleMode)) begin
            cnEvent = 16'h0000;
        end

        if (axiReq.awvalid && !st_r.awHave && !st_r.bValid) begin
            st_nxt.awHave = 1'b1;
            st_nxt.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && !st_r.wHave && !st_r.bValid) begin
            st_nxt.wHave = 1'b1;
            st_nxt.wData = axiReq.wdata;
            st_nxt.wStrb = axiReq.wstrb;
        end
        if (wrFire) begin
            wrHit = 1'b1;
            case (wrBase)
                OFS_ANALOG: st_nxt.analog = applyOp(st_r.analog, wrData, wrMask & ANALOG_MASK,
                                                    wrOp);
                OFS_DIR:    st_nxt.dir   = applyOp(st_r.dir, wrData, wrMask, wrOp);
                OFS_LEVEL:  st_nxt.latch = applyOp(st_r.latch, wrData, wrMask, wrOp);
                OFS_LATCH:  st_nxt.latch = applyOp(st_r.latch, wrData, wrMask, wrOp);
                OFS_ODC:    st_nxt.odc   = applyOp(st_r.odc, wrData, wrMask, wrOp);
                OFS_PU:     st_nxt.pu    = applyOp(st_r.pu, wrData, wrMask, wrOp);
                OFS_PD:     st_nxt.pd    = applyOp(st_r.pd, wrData, wrMask, wrOp);
                OFS_CNCON:  st_nxt.cncon = applyOp(st_r.cncon, wrData, wrMask & CNCON_MASK, wrOp);
                OFS_CNEN:   st_nxt.cnen  = applyOp(st_r.cnen, wrData, wrMask, wrOp);
                OFS_IRQMASK: st_nxt.irqMask = applyOp(st_r.irqMask, wrData, wrMask, wrOp);
                OFS_CNSTAT, OFS_IRQSTAT: wrHit = 1'b1;
                default: begin
                    wrHit = 1'b0;
                    for (int i = 0; i < NUM_INPUTS; i++) begin
                        if (wrBase == 16'(OFS_INSEL0 + 16'(i) * INSEL_STRIDE)) begin
                            wrHit = 1'b1;
                            selNew = applyOp({12'h000, st_r.insel[i]}, wrData,
                                             {12'h000, {4{st_r.wStrb[0]}}}, wrOp);
                            st_nxt.insel[i] = selNew[SEL_W-1:0];
                        end
                    end
                end
            endcase
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp  = wrHit ? RESP_OKAY : RESP_DECERR;
        end
        if (st_r.bValid && axiReq.bready) begin
            st_nxt.bValid = 1'b0;
        end

        if (rdFire) begin
            rdHit = 1'b1;
            case (rdBase)
                OFS_ANALOG:  rdVal = st_r.analog;
                OFS_DIR:     rdVal = st_r.dir;
                OFS_LEVEL:   rdVal = st_r.level;
                OFS_LATCH:   rdVal = st_r.latch;
                OFS_ODC:     rdVal = st_r.odc;
                OFS_PU:      rdVal = st_r.pu;
                OFS_PD:      rdVal = st_r.pd;
                OFS_CNCON:   rdVal = st_r.cncon;
                OFS_CNEN:    rdVal = st_r.cnen;
                OFS_CNSTAT:  rdVal = st_r.cnstat;
                OFS_IRQSTAT: rdVal = st_r.irqStat;
                OFS_IRQMASK: rdVal = st_r.irqMask;
                default: begin
                    rdHit = 1'b0;
                    for (int i = 0; i < NUM_INPUTS; i++) begin
                        if (rdBase == 16'(OFS_INSEL0 + 16'(i) * INSEL_STRIDE)) begin
                            rdHit = 1'b1;
                            rdVal = {12'h000, st_r.insel[i]};
                        end
                    end
                end
            endcase
            // Alias addresses are write-only views; reading them returns zero.
            if (rdOp != OP_WRITE) begin
                rdVal = 16'h0000;
            end
            clrCn  = rdHit && rdOp == OP_WRITE && rdBase == OFS_LEVEL;
            clrIrq = rdHit && rdOp == OP_WRITE && rdBase == OFS_IRQSTAT;
            st_nxt.rValid = 1'b1;
            st_nxt.rData  = {16'h0000, rdVal};
            st_nxt.rResp  = rdHit ? RESP_OKAY : RESP_DECERR;
        end else if (st_r.rValid && axiReq.rready) begin
            st_nxt.rValid = 1'b0;
        end

        // A change arriving with the clearing read is kept: set wins over clear.
        st_nxt.cnstat  = (clrCn ? 16'h0000 : st_r.cnstat) | cnEvent;
        st_nxt.irqStat = (clrIrq ? 16'h0000 : st_r.irqStat) | cnEvent;

        // Remapped peripherals take the pin ahead of the latch, but never an analog pin.
        periphWin = periphOutEn & ~st_r.analog & IMPL_MASK;
        drvVal    = (periphWin & periphOutVal) | (~periphWin & st_r.latch);
        st_nxt.pinOut  = drvVal & IMPL_MASK;
        st_nxt.pinOeN  = ~((periphWin | ~st_r.dir) & ~st_r.analog & IMPL_MASK)
                         | (st_r.odc & drvVal);
        for (int i = 0; i < NUM_INPUTS; i++) begin
            st_nxt.remap[i] = st_r.level[st_r.insel[i]] & ~st_r.analog[st_r.insel[i]];
        end

        if (reset) begin
            st_nxt         = '0;
            st_nxt.dir     = DIR_RESET;
            st_nxt.analog  = ANLG_RESET;
            st_nxt.latch   = RST_LATCH;
            st_nxt.odc     = RST_ZERO;
            st_nxt.pinOeN  = 16'hffff;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign axiRsp.awready = !st_r.awHave && !st_r.bValid;
    assign axiRsp.wready  = !st_r.wHave && !st_r.bValid;
    assign axiRsp.bvalid  = st_r.bValid;
    assign axiRsp.bresp   = st_r.bResp;
    assign axiRsp.arready = !st_r.rValid;
    assign axiRsp.rvalid  = st_r.rValid;
    assign axiRsp.rdata   = st_r.rData;
    assign axiRsp.rresp   = st_r.rResp;
    assign pinOut         = st_r.pinOut;
    assign pinOutEnN      = st_r.pinOeN;
    assign pullUpEn       = st_r.pu;
    assign pullDownEn     = st_r.pd;
    assign analogEn       = st_r.analog;
    assign remapIn        = st_r.remap;
    assign irq            = |(st_r.irqStat & st_r.irqMask);

    logic sel0Level;
    assign sel0Level = st_r.level[st_r.insel[0]] & ~st_r.analog[st_r.insel[0]];

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence dirClrWrite;
        wrFire && wrBase == OFS_DIR && wrOp == OP_CLR;
    endsequence
    sequence odcSetWrite;
        wrFire && wrBase == OFS_ODC && wrOp == OP_SET;
    endsequence
    sequence puInvWrite;
        wrFire && wrBase == OFS_PU && wrOp == OP_INV;
    endsequence

    AST_DIR_RESET: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> st_r.dir == DIR_RESET) else $error("Direction reset value wrong.");
    AST_CTRL_RESET: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> st_r.odc == 16'h0000 && st_r.pu == 16'h0000 && st_r.pd == 16'h0000
                  && st_r.cnen == 16'h0000 && st_r.cncon == 16'h0000)
        else $error("Control register not cleared by reset.");
    AST_UPPER_ZERO: assert property (axiRsp.rvalid |-> axiRsp.rdata[31:16] == 16'h0000)
        else $error("Upper read bits not zero.");
    AST_ABSENT_PINS: assert property (((st_r.dir | st_r.latch | st_r.pu | st_r.pd | st_r.cnen
        | st_r.odc) & ~IMPL_MASK) == 16'h0000) else $error("Absent pin bit is set.");
    AST_CLR_ALIAS: assert property (dirClrWrite |=> st_r.dir == ($past(st_r.dir)
        & ~($past(wrData) & $past(wrMask)))) else $error("Clear alias altered wrong bits.");
    AST_SET_ALIAS: assert property (odcSetWrite |=> st_r.odc == ($past(st_r.odc)
        | ($past(wrData) & $past(wrMask)))) else $error("Set alias altered wrong bits.");
    AST_INV_ALIAS: assert property (puInvWrite |=> st_r.pu == ($past(st_r.pu)
        ^ ($past(wrData) & $past(wrMask)))) else $error("Invert alias altered wrong bits.");
    AST_PERIPH_WINS: assert property (1'b1 |=> ((st_r.pinOut ^ $past(periphOutVal))
        & $past(periphWin)) == 16'h0000) else $error("Remapped peripheral lost its pin.");
    AST_ANALOG_KEEPS: assert property (1'b1 |=> ($past(st_r.analog) & ~st_r.pinOeN)
        == 16'h0000) else $error("Analog pin driven digitally.");
    AST_REMAP_ROUTE: assert property (1'b1 |=> st_r.remap[0] == $past(sel0Level))
        else $error("Remapped input does not follow its selected pin.");
endmodule

// *** test/pbio_pin_model.sv ***
// Pad model for the sixteen port pins, seen from the board side.
// Assumes the bench supplies the external drive; design drive wins where enabled.
module pbio_pin_model import pbio_pkg::*; (
    input  wire logic [PINS-1:0] pinOut,
    input  wire logic [PINS-1:0] pinOutEnN,
    input  wire logic [PINS-1:0] pullUpEn,
    input  wire logic [PINS-1:0] pullDownEn,
    input  wire logic            clk,
    input  wire logic [PINS-1:0] extEn,
    input  wire logic [PINS-1:0] extVal,
    output logic [PINS-1:0]      pinLvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PINS-1:0] last_r;
    always_ff @(posedge clk) begin
        last_r <= pinLvl;
    end
    // A pad that nobody drives or pulls flips each cycle, so a stale level never passes.
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (!pinOutEnN[i]) pinLvl[i] = pinOut[i];
            else if (extEn[i]) pinLvl[i] = extVal[i];
            else if (pullUpEn[i]) pinLvl[i] = 1'b1;
            else if (pullDownEn[i]) pinLvl[i] = 1'b0;
            else pinLvl[i] = ~last_r[i];
        end
    end
endmodule

// *** test/pbio_port_b_remap_test.sv ***
// Self-checking bench: register access over AXI4-Lite, remapping, pin priority, interrupt.
// Assumes the pad model resolves every pin from design drive and external drive.
module pbio_port_b_remap_test import pbio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    pbio_axi_req_t   req = '0;
    pbio_axi_rsp_t   rsp;
    pbio_axi_rsp_t   rspRed;
    logic            idle = 1'b0;
    logic [PINS-1:0] pinLvl, pinOut, pinOutEnN, pullUpEn, pullDownEn, analogEn;
    logic [PINS-1:0] extVal = 16'h00a5;
    logic [PINS-1:0] pEn = 16'h0000;
    logic [PINS-1:0] pVal = 16'h0000;
    logic [3:0]      remapIn;
    logic            irq;
    int              failures = 0;
    int              tests_run = 0;

    always #10 clk = ~clk;

    pbio_port_b_remap pbio_port_b_remap_i (.clk(clk), .reset(reset), .axiReq(req), .axiRsp(rsp),
        .pinIn(pinLvl), .pinOut(pinOut), .pinOutEnN(pinOutEnN), .pullUpEn(pullUpEn),
        .pullDownEn(pullDownEn), .analogEn(analogEn), .periphOutEn(pEn), .periphOutVal(pVal),
        .idleMode(idle), .remapIn(remapIn), .irq(irq));
    pbio_pin_model pbio_pin_model_i (.clk(clk), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extEn(16'hffff), .extVal(extVal),
        .pinLvl(pinLvl));
    // A second port built without pins 12 and 6 shares the bus, so every read checks both.
    if (1'b1) begin : reducedPort
        pbio_port_b_remap #(.REDUCED(1'b1)) pbio_port_b_remap_i (.clk(clk), .reset(reset),
            .axiReq(req), .axiRsp(rspRed), .pinIn(pinLvl), .pinOut(), .pinOutEnN(),
            .pullUpEn(), .pullDownEn(), .analogEn(), .periphOutEn(pEn), .periphOutVal(pVal),
            .idleMode(idle), .remapIn(), .irq());
    end

    task automatic summarize();
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chkD(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkR(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Handshakes are judged at the falling edge, so the value seen is the one the
    // next rising edge samples, and the release lands just after that edge.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic a1, w1, b1, done;
        logic [1:0] r;
        done = 1'b0;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            a1 = req.awvalid && rsp.awready;
            w1 = req.wvalid && rsp.wready;
            b1 = req.bready && rsp.bvalid;
            r = rsp.bresp;
            @(posedge clk);
            if (a1) req.awvalid <= 1'b0;
            if (w1) req.wvalid <= 1'b0;
            if (b1) begin
                req.bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            failures++;
            summarize();
        end
        chkR(r, er);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic a1, b1, done;
        logic [1:0] r;
        logic [31:0] d;
        logic [31:0] dRed;
        done = 1'b0;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            a1 = req.arvalid && rsp.arready;
            b1 = req.rready && rsp.rvalid;
            r = rsp.rresp;
            d = rsp.rdata;
            dRed = rspRed.rdata;
            @(posedge clk);
            if (a1) req.arvalid <= 1'b0;
            if (b1) begin
                req.rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            failures++;
            summarize();
        end
        chkR(r, er);
        chkD(d, ed);
        chkD(dRed, ed & {16'h0000, PIN_MASK_REDUCED});
    endtask

    initial begin
        logic [15:0] ofs [8];
        ofs = '{OFS_DIR, OFS_ODC, OFS_PU, OFS_PD, OFS_CNCON, OFS_CNEN, OFS_CNSTAT, OFS_IRQMASK};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(ofs[i], (i == 0) ? 32'h0000ffff : 32'h00000000, RESP_OKAY);
        end
        rd(OFS_ANALOG, 32'h0000f00f, RESP_OKAY);
        wr(OFS_PD, 32'hffffffff, RESP_OKAY);
        rd(OFS_PD, 32'h0000ffff, RESP_OKAY);
        chkD({16'h0000, pullDownEn}, 32'h0000ffff);
        wr(OFS_CNCON, 32'hffffffff, RESP_OKAY);
        rd(OFS_CNCON, 32'h0000a000, RESP_OKAY);
        wr(OFS_CNCON, 32'h00000000, RESP_OKAY);
        wr(OFS_PU + 16'h0008, 32'h00000f0f, RESP_OKAY);
        wr(OFS_PU + 16'h0004, 32'h00000003, RESP_OKAY);
        wr(OFS_PU + 16'h000c, 32'h000000ff, RESP_OKAY);
        rd(OFS_PU, 32'h00000ff3, RESP_OKAY);
        rd(OFS_PU + 16'h0008, 32'h00000000, RESP_OKAY);
        chkD({16'h0000, pullUpEn}, 32'h00000ff3);
        wr(16'h7000, 32'h00000001, RESP_DECERR);
        rd(16'h7000, 32'h00000000, RESP_DECERR);
        wr(OFS_ANALOG, 32'h00000000, RESP_OKAY);
        wr(OFS_INSEL0 + INSEL_STRIDE, 32'h00000002, RESP_OKAY);
        for (int k = 0; k < PINS; k++) begin
            wr(OFS_INSEL0, 32'(k), RESP_OKAY);
            repeat (6) @(posedge clk);
            chkD(32'(remapIn[0]), 32'(extVal[k]));
            chkD(32'(remapIn[1]), 32'(extVal[2]));
        end
        wr(OFS_DIR + 16'h0004, 32'h00000008, RESP_OKAY);
        repeat (2) @(posedge clk);
        chkD({16'h0000, pinOutEnN}, 32'h0000fff7);
        chkD(32'(pinOut[3]), 32'h00000000);
        pEn <= 16'h0008;
        pVal <= 16'h0008;
        repeat (3) @(posedge clk);
        chkD(32'(pinOut[3]), 32'h00000001);
        chkD(32'(pinOutEnN[3]), 32'h00000000);
        wr(OFS_ANALOG + 16'h0008, 32'h00000001, RESP_OKAY);
        wr(OFS_INSEL0, 32'h00000000, RESP_OKAY);
        repeat (6) @(posedge clk);
        chkD(32'(remapIn[0]), 32'h00000000);
        chkD({16'h0000, analogEn}, 32'h00000001);
        wr(OFS_ANALOG, 32'h00000000, RESP_OKAY);
        wr(OFS_IRQMASK, 32'h00000002, RESP_OKAY);
        wr(OFS_CNEN, 32'h00000002, RESP_OKAY);
        wr(OFS_CNCON, 32'h00008000, RESP_OKAY);
        extVal <= 16'h00a7;
        repeat (8) @(posedge clk);
        chkD(32'(irq), 32'h00000001);
        rd(OFS_CNSTAT, 32'h00000002, RESP_OKAY);
        rd(OFS_LEVEL, 32'h000000af, RESP_OKAY);
        rd(OFS_CNSTAT, 32'h00000000, RESP_OKAY);
        rd(OFS_IRQSTAT, 32'h00000002, RESP_OKAY);
        chkD(32'(irq), 32'h00000000);
        rd(OFS_IRQSTAT, 32'h00000000, RESP_OKAY);
        wr(OFS_IRQMASK, 32'h00000000, RESP_OKAY);
        extVal <= 16'h00a5;
        repeat (8) @(posedge clk);
        chkD(32'(irq), 32'h00000000);
        rd(OFS_IRQSTAT, 32'h00000002, RESP_OKAY);
        rd(OFS_LEVEL, 32'h000000ad, RESP_OKAY);
        wr(OFS_CNCON, 32'h0000a000, RESP_OKAY);
        idle <= 1'b1;
        extVal <= 16'h00a7;
        repeat (8) @(posedge clk);
        rd(OFS_CNSTAT, 32'h00000000, RESP_OKAY);
        rd(OFS_LEVEL, 32'h000000af, RESP_OKAY);
        summarize();
    end
endmodule
